// ### src/aes_pkg.sv
// Shared constants, types and register map of the alarm and event supervisor
package aes_pkg;
	// Measurement width and bus width
	localparam int MEAS_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_VPROT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IPROT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PPROT = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_EVU = 8'h10;
	localparam logic [ADDR_W-1:0] REG_EVI = 8'h14;
	localparam logic [ADDR_W-1:0] REG_EVP = 8'h18;
	localparam logic [ADDR_W-1:0] REG_EVACT = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] REG_ACK = 8'h24;
	localparam logic [ADDR_W-1:0] REG_PIN = 8'h28;
	localparam logic [ADDR_W-1:0] REG_UNLOCK = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h30;

	// Control register bit positions
	localparam int CTRL_AUTO_OT = 1;
	localparam int CTRL_AUTO_PF = 2;
	localparam int CTRL_SOUND = 3;
	localparam int CTRL_PLOCK = 4;
	localparam int CTRL_ONOFF_OK = 5;
	localparam int CTRL_PIN_EN = 6;
	localparam int CTRL_LLOCK = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Command register bits
	localparam int CMD_ON = 0;
	localparam int CMD_OFF = 1;

	// Alarm bit order in status and acknowledge words
	localparam int AL_V = 0;
	localparam int AL_I = 1;
	localparam int AL_P = 2;
	localparam int AL_PF = 3;
	localparam int AL_OT = 4;
	localparam int N_AL = 5;
	// Event bit order
	localparam int EV_LOW_V = 0;
	localparam int EV_HIGH_V = 1;
	localparam int EV_LOW_I = 2;
	localparam int EV_HIGH_I = 3;
	localparam int EV_HIGH_P = 4;
	localparam int N_EV = 5;
	// Status word field positions
	localparam int ST_EV_LSB = 8;
	localparam int ST_OUT = 16;
	localparam int ST_UREQ = 17;
	localparam int ST_PLOCK = 18;
	localparam int ST_LLOCK = 19;

	// Default protection threshold is 110 percent of rating
	localparam int PROT_PCT_NUM = 11;
	localparam int PROT_PCT_DEN = 10;

	// Unlock confirmation window and clock rate
	localparam longint UNLOCK_WIN_MS = 5000;
	localparam longint CLK_KHZ = 200000;
	localparam int UNLOCK_CYC = int'(UNLOCK_WIN_MS * CLK_KHZ);

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Event action selector
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_SIGNAL = 2'b01,
		ACT_WARNING = 2'b10,
		ACT_ALARM = 2'b11
	} aes_act_t;

	// Measured output quantities, one group
	typedef struct packed {
		logic [MEAS_W-1:0] volt;
		logic [MEAS_W-1:0] curr;
		logic [MEAS_W-1:0] power;
	} aes_meas_t;

	// Pair of event thresholds
	typedef struct packed {
		logic [MEAS_W-1:0] high;
		logic [MEAS_W-1:0] low;
	} aes_evthr_t;
endpackage : aes_pkg

// ### src/aes_supervisor.sv
// Alarm, user event and panel/limits lock supervisor with AXI4-Lite slave
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Any protection alarm forces output off
// - Acknowledge accepted only after cause cleared
// - Heat and supply alarms may auto resume
// - Alarm flag stays until user acknowledges
// - Voltage reaching threshold raises alarm, off
// - Current reaching threshold raises alarm, off
// - Power reaching threshold raises alarm, off
// - Temperature limit raises alarm, output off
// - Protection thresholds reset to 110 percent
// - Config bit enables acoustic alarm signal
// - All events reset to disabled action
// - Events evaluated only while output on
// - Each event has own four-value action
// - Low and high voltage events
// - Low and high current events
// - High power event
// - Event with alarm action forces output off
// - Panel lock rejects changes, raises unlock request
// - Lock modes full or on/off allowed, PIN
// - PIN demanded on every unlock when enabled
// - Unlock confirmation must come within window
// - Limits lock blocks limits until PIN/reset
// - Action levels signal, warning, alarm indications
module aes_supervisor import aes_pkg::*; #(
	parameter int RATED_V = 16'h2710, // Rated voltage in measurement units
	parameter int RATED_I = 16'h1770, // Rated current
	parameter int RATED_P = 16'h3A98, // Rated power
	parameter int UNLOCK_CYCLES = UNLOCK_CYC // Confirmation window length
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire aes_meas_t meas, // Same-clock measurement path
	input wire logic overheatPin, // Asynchronous sensor pin
	input wire logic supplyFailPin, // Asynchronous sensor pin
	input wire logic panelChange, // Knob or touch change attempt pulse
	input wire logic panelOnOff, // On/off button pulse
	input wire logic unlockTap, // Unlock confirmation pulse
	input wire logic [15:0] pinEntry, // PIN offered with confirmation
	output logic outEnable_q,
	output logic buzzer_q,
	output logic statusInd_q,
	output logic warnInd_q,
	output logic alarmInd_q,
	output logic unlockReq_q,
	output logic panelAccept_q,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Refuse ratings whose 110 percent default does not fit a threshold
	localparam int V_DEF = RATED_V * PROT_PCT_NUM / PROT_PCT_DEN;
	localparam int I_DEF = RATED_I * PROT_PCT_NUM / PROT_PCT_DEN;
	localparam int P_DEF = RATED_P * PROT_PCT_NUM / PROT_PCT_DEN;
	if (V_DEF >= 2**MEAS_W || I_DEF >= 2**MEAS_W ||
			P_DEF >= 2**MEAS_W) begin : g_bad_rating
		$error("Rating too large for threshold width");
	end
	// The countdown register is 30 bits wide
	if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES >= 2**30) begin : g_bad_window
		$error("Unlock window out of counter range");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] otSync_q; // Bit 0 is metastable stage
	logic [1:0] pfSync_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			otSync_q <= 2'b00;
			pfSync_q <= 2'b00;
		end else begin
			otSync_q <= {otSync_q[0], overheatPin};
			pfSync_q <= {pfSync_q[0], supplyFailPin};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration storage
	logic [7:0] ctrl_q; // Control bits
	logic [MEAS_W-1:0] vProt_q, iProt_q, pProt_q; // Protection thresholds
	aes_evthr_t evU_q, evI_q; // Event thresholds
	logic [MEAS_W-1:0] evP_q;
	aes_act_t act_q [N_EV]; // Per event action
	logic [15:0] pin_q; // Shared unlock PIN
	logic [N_AL-1:0] alarm_q; // Sticky alarm bits
	logic [N_EV-1:0] evFlag_q; // Sticky event bits
	logic resumeArm_q; // Output was on before resumable alarm

	////////////////////////////////////////////////////////////////////////
	// Bus slave handshake state
	logic [ADDR_W-1:0] awAddr_q;
	logic [DATA_W-1:0] wData_q;
	logic [3:0] wStrb_q;
	logic awHeld_q, wHeld_q;
	wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
	wire arTake = s_axi_arvalid & s_axi_arready;

	// Byte-lane merge for writable words
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = nw[8*b +: 8];
		return res;
	endfunction : merge

	// Write decode
	wire wrCtrl = doWrite & (awAddr_q == REG_CTRL);
	wire wrLimit = doWrite & ((awAddr_q == REG_VPROT) |
		(awAddr_q == REG_IPROT) | (awAddr_q == REG_PPROT));
	wire limitOk = ~ctrl_q[CTRL_LLOCK]; // Limits reachable
	wire wrEvU = doWrite & (awAddr_q == REG_EVU);
	wire wrEvI = doWrite & (awAddr_q == REG_EVI);
	wire wrEvP = doWrite & (awAddr_q == REG_EVP);
	wire wrAct = doWrite & (awAddr_q == REG_EVACT);
	wire wrAck = doWrite & (awAddr_q == REG_ACK);
	wire wrPin = doWrite & (awAddr_q == REG_PIN);
	wire wrUnl = doWrite & (awAddr_q == REG_UNLOCK);
	wire wrCmd = doWrite & (awAddr_q == REG_CMD);
	wire wrMapped = wrCtrl | wrEvU | wrEvI | wrEvP | wrAct | wrAck |
		wrPin | wrUnl | wrCmd | (awAddr_q == REG_STATUS);
	wire wrErr = ~wrMapped & ~(wrLimit & limitOk);
	wire [DATA_W-1:0] ctrlMerged = merge({24'h00_0000, ctrl_q},
		wData_q, wStrb_q);
	wire [DATA_W-1:0] limitMerged = merge({16'h0000,
		(awAddr_q == REG_VPROT) ? vProt_q :
		(awAddr_q == REG_IPROT) ? iProt_q : pProt_q}, wData_q, wStrb_q);
	// Limits unlock only with the correct PIN
	wire limitUnlock = wrUnl & (wData_q[15:0] == pin_q);

	////////////////////////////////////////////////////////////////////////
	// Comparators
	logic [N_AL-1:0] alCond; // Alarm causes present
	assign alCond[AL_V] = meas.volt >= vProt_q;
	assign alCond[AL_I] = meas.curr >= iProt_q;
	assign alCond[AL_P] = meas.power >= pProt_q;
	assign alCond[AL_PF] = pfSync_q[1];
	assign alCond[AL_OT] = otSync_q[1];
	logic [N_EV-1:0] evCmp; // Raw event comparisons
	assign evCmp[EV_LOW_V] = meas.volt < evU_q.low;
	assign evCmp[EV_HIGH_V] = meas.volt > evU_q.high;
	assign evCmp[EV_LOW_I] = meas.curr < evI_q.low;
	assign evCmp[EV_HIGH_I] = meas.curr > evI_q.high;
	assign evCmp[EV_HIGH_P] = meas.power > evP_q;

	// Per event qualification, one slice per event
	logic [N_EV-1:0] evFire, evAlarm, evWarn, evSig;
	for (genvar e = 0; e < N_EV; e++) begin : g_ev
		// Events only watched while output is on
		assign evFire[e] = outEnable_q & evCmp[e] & (act_q[e] != ACT_NONE);
		assign evAlarm[e] = evFlag_q[e] & (act_q[e] == ACT_ALARM);
		assign evWarn[e] = evFlag_q[e] & (act_q[e] == ACT_WARNING);
		assign evSig[e] = evFlag_q[e];
	end

	////////////////////////////////////////////////////////////////////////
	// Output control
	wire resumable = (alCond[AL_OT] & ctrl_q[CTRL_AUTO_OT]) |
		(alCond[AL_PF] & ctrl_q[CTRL_AUTO_PF]);
	wire hardCause = |alCond[AL_P:AL_V] |
		(alCond[AL_OT] & ~ctrl_q[CTRL_AUTO_OT]) |
		(alCond[AL_PF] & ~ctrl_q[CTRL_AUTO_PF]);
	logic [N_EV-1:0] evAlarmFire;
	for (genvar e = 0; e < N_EV; e++) begin : g_eval
		assign evAlarmFire[e] = evFire[e] & (act_q[e] == ACT_ALARM);
	end
	wire forceOff = (|alCond) | (|evAlarmFire);
	wire onOffOk = ~ctrl_q[CTRL_PLOCK] | ctrl_q[CTRL_ONOFF_OK];
	wire btnOn = panelOnOff & onOffOk & ~outEnable_q;
	wire btnOff = panelOnOff & onOffOk & outEnable_q;
	// Switch-on refused while a voltage, current or power alarm is pending
	wire onReq = ((wrCmd & wData_q[CMD_ON]) | btnOn) & ~(|alarm_q[AL_P:AL_V]);
	wire offReq = (wrCmd & wData_q[CMD_OFF]) | btnOff;
	wire doResume = resumeArm_q & ~(|alCond);

	// Output enable and resume memory
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			outEnable_q <= 1'b0;
			resumeArm_q <= 1'b0;
		end else begin
			if (forceOff)
				outEnable_q <= 1'b0;
			else if (doResume)
				outEnable_q <= 1'b1;
			else if (offReq)
				outEnable_q <= 1'b0;
			else if (onReq)
				outEnable_q <= 1'b1;
			// Arm only if nothing else demands a manual restart
			if (hardCause | offReq | (|evAlarmFire))
				resumeArm_q <= 1'b0;
			else if (resumable & outEnable_q)
				resumeArm_q <= 1'b1;
			else if (doResume)
				resumeArm_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky alarm and event flags; a live cause blocks the clear
	wire [N_AL-1:0] alAck = {N_AL{wrAck}} & wData_q[N_AL-1:0];
	wire [N_EV-1:0] evAck = {N_EV{wrAck}} & wData_q[ST_EV_LSB +: N_EV];
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			alarm_q <= '0;
			evFlag_q <= '0;
		end else begin
			alarm_q <= alCond | (alarm_q & ~(alAck & ~alCond));
			evFlag_q <= evFire | (evFlag_q & ~(evAck & ~evFire));
		end
	end

	// Indications and sound
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			statusInd_q <= 1'b0;
			warnInd_q <= 1'b0;
			alarmInd_q <= 1'b0;
			buzzer_q <= 1'b0;
		end else begin
			statusInd_q <= |evSig;
			warnInd_q <= |evWarn;
			alarmInd_q <= (|alarm_q) | (|evAlarm);
			buzzer_q <= ctrl_q[CTRL_SOUND] & ((|alarm_q) | (|evAlarm));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Panel lock and unlock request
	typedef enum logic {LK_IDLE, LK_REQ} aes_lkst_t;
	aes_lkst_t lkSt_q;
	logic [29:0] lkCnt_q; // Confirmation window countdown
	wire attempt = ctrl_q[CTRL_PLOCK] & (panelChange | (panelOnOff & ~onOffOk));
	wire pinGood = ~ctrl_q[CTRL_PIN_EN] | (pinEntry == pin_q);
	wire confirm = (lkSt_q == LK_REQ) & unlockTap & pinGood;
	wire lkTimeout = (lkSt_q == LK_REQ) & (lkCnt_q == 30'd0);

	// Request window state machine
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lkSt_q <= LK_IDLE;
			lkCnt_q <= 30'd0;
		end else begin
			case (lkSt_q)
				LK_IDLE: begin
					if (attempt) begin
						lkSt_q <= LK_REQ;
						lkCnt_q <= 30'(UNLOCK_CYCLES - 1);
					end
				end
				LK_REQ: begin
					// Window closes on success or expiry
					if (confirm | lkTimeout | ~ctrl_q[CTRL_PLOCK])
						lkSt_q <= LK_IDLE;
					else
						lkCnt_q <= lkCnt_q - 30'd1;
				end
				default: lkSt_q <= LK_IDLE;
			endcase
		end
	end

	// Request flag and accepted panel changes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			unlockReq_q <= 1'b0;
			panelAccept_q <= 1'b0;
		end else begin
			unlockReq_q <= (lkSt_q == LK_REQ) & ~confirm & ~lkTimeout;
			panelAccept_q <= panelChange & ~ctrl_q[CTRL_PLOCK];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and configuration registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
			vProt_q <= MEAS_W'(V_DEF);
			iProt_q <= MEAS_W'(I_DEF);
			pProt_q <= MEAS_W'(P_DEF);
			evU_q <= '0;
			evI_q <= '0;
			evP_q <= '0;
			pin_q <= 16'h0000;
			for (int e = 0; e < N_EV; e++)
				act_q[e] <= ACT_NONE;
		end else begin
			if (wrCtrl) begin
				ctrl_q[CTRL_LLOCK-1:0] <= ctrlMerged[CTRL_LLOCK-1:0];
				// Limits lock is set here but only a PIN or reset clears it
				if (ctrlMerged[CTRL_LLOCK])
					ctrl_q[CTRL_LLOCK] <= 1'b1;
			end
			if (confirm)
				ctrl_q[CTRL_PLOCK] <= 1'b0;
			if (limitUnlock)
				ctrl_q[CTRL_LLOCK] <= 1'b0;
			if (wrLimit & limitOk) begin
				if (awAddr_q == REG_VPROT)
					vProt_q <= limitMerged[MEAS_W-1:0];
				if (awAddr_q == REG_IPROT)
					iProt_q <= limitMerged[MEAS_W-1:0];
				if (awAddr_q == REG_PPROT)
					pProt_q <= limitMerged[MEAS_W-1:0];
			end
			if (wrEvU)
				evU_q <= merge(evU_q, wData_q, wStrb_q);
			if (wrEvI)
				evI_q <= merge(evI_q, wData_q, wStrb_q);
			if (wrEvP)
				evP_q <= MEAS_W'(merge({16'h0000, evP_q}, wData_q,
					wStrb_q));
			if (wrPin)
				pin_q <= wData_q[15:0];
			if (wrAct)
				for (int e = 0; e < N_EV; e++)
					act_q[e] <= aes_act_t'(wData_q[2*e +: 2]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux
	logic [DATA_W-1:0] actWord, statWord, rdWord;
	always_comb begin
		actWord = '0;
		for (int e = 0; e < N_EV; e++)
			actWord[2*e +: 2] = act_q[e];
	end
	always_comb begin
		statWord = '0;
		statWord[N_AL-1:0] = alarm_q;
		statWord[ST_EV_LSB +: N_EV] = evFlag_q;
		statWord[ST_OUT] = outEnable_q;
		statWord[ST_UREQ] = unlockReq_q;
		statWord[ST_PLOCK] = ctrl_q[CTRL_PLOCK];
		statWord[ST_LLOCK] = ctrl_q[CTRL_LLOCK];
	end
	wire rdHit = (s_axi_araddr <= REG_CMD) & (s_axi_araddr[1:0] == 2'b00);
	always_comb begin
		case (s_axi_araddr)
			REG_CTRL: rdWord = {24'h00_0000, ctrl_q};
			REG_VPROT: rdWord = {16'h0000, vProt_q};
			REG_IPROT: rdWord = {16'h0000, iProt_q};
			REG_PPROT: rdWord = {16'h0000, pProt_q};
			REG_EVU: rdWord = evU_q;
			REG_EVI: rdWord = evI_q;
			REG_EVP: rdWord = {16'h0000, evP_q};
			REG_EVACT: rdWord = actWord;
			REG_STATUS: rdWord = statWord;
			default: rdWord = '0; // PIN and strobes read zero
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite channel handshakes, one write and one read at a time
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (arTake) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdWord;
				s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_prot_forces_off: assert property ((|alCond) |=> !outEnable_q)
		else $error("Output on after protection cause");
	a_volt_alarm_set: assert property (alCond[AL_V] |=> alarm_q[AL_V])
		else $error("Voltage alarm not latched");
	a_curr_alarm_off: assert property (alCond[AL_I] |=>
		alarm_q[AL_I] && !outEnable_q)
		else $error("Current alarm missed");
	a_pow_alarm_off: assert property (alCond[AL_P] |=>
		alarm_q[AL_P] && !outEnable_q)
		else $error("Power alarm missed");
	a_heat_alarm_set: assert property (alCond[AL_OT] |=>
		alarm_q[AL_OT] && !outEnable_q)
		else $error("Overheat alarm missed");
	a_ack_needs_clear: assert property (alarm_q[AL_V] && alCond[AL_V]
		|=> alarm_q[AL_V])
		else $error("Alarm cleared while cause present");
	a_sticky_hold: assert property (alarm_q[AL_OT] && !alAck[AL_OT]
		|=> alarm_q[AL_OT])
		else $error("Alarm flag dropped without acknowledge");
	a_resume_on: assert property (resumeArm_q && !(|alCond)
		|=> outEnable_q)
		else $error("No automatic resume");
	a_event_off_gate: assert property (!outEnable_q |=>
		evFlag_q == ($past(evFlag_q) & ~$past(evAck)))
		else $error("Event fired while output off");
	a_event_alarm_off: assert property ((|evAlarmFire) |=>
		!outEnable_q ##1 alarmInd_q)
		else $error("Alarm event did not switch off");
	a_sound_gate: assert property (!ctrl_q[CTRL_SOUND] |=> !buzzer_q)
		else $error("Sound while disabled");
	a_lock_request: assert property (attempt && lkSt_q == LK_IDLE
		|=> ##1 unlockReq_q && !panelAccept_q)
		else $error("No unlock request on locked change");
	a_pin_check: assert property (ctrl_q[CTRL_PIN_EN] && unlockTap &&
		pinEntry != pin_q && ctrl_q[CTRL_PLOCK] |=> ctrl_q[CTRL_PLOCK])
		else $error("Unlocked with wrong PIN");
	a_limits_hold: assert property (ctrl_q[CTRL_LLOCK] && !limitUnlock
		|=> $stable(vProt_q) && ctrl_q[CTRL_LLOCK])
		else $error("Limits changed while locked");

	c_unlock_done: cover property (confirm);
	c_resume: cover property (doResume);
	c_event_alarm: cover property (|evAlarmFire);
	c_write_err: cover property (doWrite && wrErr);
endmodule : aes_supervisor

// ### verification/aes_panel_model.sv
// Operator model that answers an unlock request with one PIN tap
`timescale 1ns/10ps
module aes_panel_model #(
	parameter int TAP_DLY = 3 // Cycles from request seen to tap
) (
	input wire logic clk_sys,
	input wire logic unlockReq_q,
	input wire logic tapEn,
	input wire logic [15:0] tapPin,
	output logic unlockTap = 1'b0,
	output logic [15:0] pinEntry = 16'h0000
);
	logic [7:0] waitCnt = 8'h00; // Cycles since request seen
	wire logic fire = unlockReq_q && tapEn && waitCnt == 8'(TAP_DLY);
	////////////////////////////////////////////////////////////////////////
	// Count saturates so a late window never sees a second tap
	always @(posedge clk_sys) begin
		if (!unlockReq_q || !tapEn) begin
			waitCnt <= 8'h00;
		end else if (waitCnt != 8'hFF) begin
			waitCnt <= waitCnt + 8'h01;
		end
		unlockTap <= fire;
		// PIN only valid with the tap; otherwise it toggles as noise
		pinEntry <= fire ? tapPin : ~pinEntry;
	end
endmodule : aes_panel_model

// ### verification/alarm_event_supervisor_tb_top.sv
// Self-checking bench for the alarm and event supervisor
`timescale 1ns/10ps
module alarm_event_supervisor_tb_top import aes_pkg::*;;
	localparam int RV = 'h2710, RI = 'h1770, RP = 'h3A98, WIN = 20;
	localparam int THR[3] = '{RV * PROT_PCT_NUM / PROT_PCT_DEN,
		RI * PROT_PCT_NUM / PROT_PCT_DEN, RP * PROT_PCT_NUM / PROT_PCT_DEN};
	logic clk_sys = 1'b0, sys_rst = 1'b1, tapEn = 1'b0;
	aes_meas_t meas = '0;
	logic overheatPin = 1'b0, supplyFailPin = 1'b0, panelChange = 1'b0;
	logic panelOnOff = 1'b0, unlockTap;
	logic [15:0] pinEntry, tapPin = 16'h0000;
	logic outEnable_q, buzzer_q, statusInd_q, warnInd_q, alarmInd_q;
	logic unlockReq_q, panelAccept_q, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF; // Full words only
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	int n_errors = 0, comparisons = 0, cycles = 0;
	aes_supervisor #(.RATED_V(RV), .RATED_I(RI), .RATED_P(RP),
		.UNLOCK_CYCLES(WIN)) DUT (.clk_sys, .sys_rst, .meas, .overheatPin,
		.supplyFailPin, .panelChange, .panelOnOff, .unlockTap, .pinEntry,
		.outEnable_q, .buzzer_q, .statusInd_q, .warnInd_q, .alarmInd_q,
		.unlockReq_q, .panelAccept_q, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	aes_panel_model #(.TAP_DLY(3)) PANEL (.clk_sys, .unlockReq_q, .tapEn,
		.tapPin, .unlockTap, .pinEntry);
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task give_verdict;
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master; each channel held until its own ready
	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk($sformatf("bresp %h", a), RESP_OKAY, r);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk($sformatf("rresp %h", a), RESP_OKAY, r);
		chk($sformatf("reg %h", a), e, d & m);
	endtask : rd
	// Pulses one change attempt, notes any accept pulse that follows
	task poke(output logic acc);
		panelChange <= 1'b1;
		@(posedge clk_sys);
		panelChange <= 1'b0;
		acc = 1'b0;
		repeat (3) begin
			@(posedge clk_sys);
			acc = acc | panelAccept_q;
		end
	endtask : poke
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 3; k++) begin
			rd(REG_VPROT + 8'(4 * k), 32'h0000_FFFF, THR[k]);
		end
		rd(REG_EVACT, 32'h0000_03FF, 32'h0000_0000);
		axr(8'h40, d, r);
		chk("unmapped", RESP_SLVERR, r);
	endtask : t_reset
	task t_prot;
		aes_meas_t m;
		for (int k = 0; k < 3; k++) begin
			m = '0;
			m[16 * (2 - k) +: 16] = 16'(THR[k] - 1);
			meas <= m;
			wr(REG_CMD, 32'h0000_0001);
			repeat (3) @(posedge clk_sys);
			chk("below", 1, outEnable_q);
			m[16 * (2 - k) +: 16] = 16'(THR[k]);
			meas <= m;
			repeat (3) @(posedge clk_sys);
			chk("tripped", 0, outEnable_q);
			chk("alarmInd", 1, alarmInd_q);
			wr(REG_ACK, 1 << k);
			rd(REG_STATUS, 1 << k, 1 << k);
			meas <= '0;
			wr(REG_CMD, 32'h0000_0001);
			chk("stuck off", 0, outEnable_q);
			wr(REG_ACK, 1 << k);
			rd(REG_STATUS, 32'h0000_001F, 32'h0000_0000);
		end
	endtask : t_prot
	task t_heat;
		wr(REG_CTRL, 1 << CTRL_AUTO_OT);
		wr(REG_CMD, 32'h0000_0001);
		overheatPin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("heat off", 0, outEnable_q);
		overheatPin <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk("resumed", 1, outEnable_q);
		rd(REG_STATUS, 1 << AL_OT, 1 << AL_OT);
		wr(REG_ACK, 1 << AL_OT);
		rd(REG_STATUS, 1 << AL_OT, 0);
		wr(REG_CMD, 1 << CMD_OFF);
	endtask : t_heat
	task t_event;
		wr(REG_EVU, 32'h1000_0100);
		wr(REG_EVACT, 32'(ACT_ALARM) << (2 * EV_HIGH_V));
		wr(REG_CTRL, 1 << CTRL_SOUND);
		meas <= '{volt: 16'h2000, curr: 16'h0000, power: 16'h0000};
		rd(REG_STATUS, 32'h0000_1F00, 0);
		wr(REG_CMD, 32'h0000_0001);
		repeat (3) @(posedge clk_sys);
		chk("ev off", 0, outEnable_q);
		chk("ev alarm", 1, alarmInd_q);
		chk("buzzer", 1, buzzer_q);
		rd(REG_STATUS, 32'h0000_1F00, 1 << (ST_EV_LSB + EV_HIGH_V));
		meas <= '{volt: 16'h0800, curr: 16'h0000, power: 16'h0000};
		wr(REG_ACK, 32'h0000_1F00);
		wr(REG_EVACT, 32'(ACT_WARNING) << (2 * EV_HIGH_V));
		wr(REG_CMD, 32'h0000_0001);
		meas <= '{volt: 16'h2000, curr: 16'h0000, power: 16'h0000};
		repeat (3) @(posedge clk_sys);
		chk("warn on", 1, outEnable_q);
		chk("warnInd", 1, warnInd_q);
		chk("statusInd", 1, statusInd_q);
		wr(REG_CMD, 1 << CMD_OFF);
		meas <= '0;
		wr(REG_ACK, 32'h0000_1F00);
	endtask : t_event
	task t_panel;
		logic acc;
		wr(REG_PIN, 32'h0000_1234);
		wr(REG_CTRL, (1 << CTRL_PLOCK) | (1 << CTRL_PIN_EN));
		poke(acc);
		chk("locked accept", 0, acc);
		chk("unlockReq", 1, unlockReq_q);
		repeat (WIN + 5) @(posedge clk_sys);
		chk("req expired", 0, unlockReq_q);
		tapPin <= 16'h1111;
		tapEn <= 1'b1;
		poke(acc);
		repeat (WIN + 5) @(posedge clk_sys);
		rd(REG_STATUS, 1 << ST_PLOCK, 1 << ST_PLOCK);
		tapPin <= 16'h1234;
		poke(acc);
		repeat (10) @(posedge clk_sys);
		rd(REG_STATUS, 1 << ST_PLOCK, 0);
		poke(acc);
		chk("free accept", 1, acc);
		wr(REG_CTRL, (1 << CTRL_PLOCK) | (1 << CTRL_ONOFF_OK));
		panelOnOff <= 1'b1;
		@(posedge clk_sys);
		panelOnOff <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("button on", 1, outEnable_q);
		wr(REG_CMD, 1 << CMD_OFF);
	endtask : t_panel
	task t_limits;
		logic [1:0] r;
		wr(REG_CTRL, 1 << CTRL_LLOCK);
		axw(REG_VPROT, 32'h0000_0100, r);
		chk("locked write", RESP_SLVERR, r);
		rd(REG_VPROT, 32'h0000_FFFF, THR[0]);
		wr(REG_UNLOCK, 32'h0000_1234);
		wr(REG_VPROT, 32'h0000_0100);
		rd(REG_VPROT, 32'h0000_FFFF, 32'h0000_0100);
	endtask : t_limits
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_prot();
		t_heat();
		t_event();
		t_panel();
		t_limits();
		give_verdict();
	end
endmodule : alarm_event_supervisor_tb_top
